// *** include/bypass_host_consts.svh ***
// Purpose: Constants for the unlock bypass host sequencer
// Assumes: 10 MHz clock, flash bus writes qualified by write strobe
// Notes: Codes are bus data values, addresses are unlock addresses
`ifndef BYPASS_HOST_CONSTS_SVH
`define BYPASS_HOST_CONSTS_SVH
`define AW 23
`define DW 16
`define CLK_PERIOD_NS 100
`define T_WR_PULSE_NS 100
`define T_READ_NS 100
`define WR_CYC ((`T_WR_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define RD_CYC ((`T_READ_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define UNLOCK1_BYTE 23'h000AAA
`define UNLOCK2_BYTE 23'h000555
`define UNLOCK1_WORD 23'h000555
`define UNLOCK2_WORD 23'h0002AA
`define D_UNLOCK1 16'h00AA
`define D_UNLOCK2 16'h0055
`define D_ENTER 16'h0020
`define D_PROGRAM 16'h00A0
`define D_ERASE_SETUP 16'h0080
`define D_BLOCK_ERASE 16'h0030
`define D_CHIP_ERASE 16'h0010
`define D_BUF_LOAD 16'h0025
`define D_ENH_LOAD 16'h0033
`define D_CONFIRM 16'h0029
`define D_EXIT1 16'h0090
`define D_EXIT2 16'h0000
`define D_RESET 16'h00F0
`define MAX_N_BYTE 8'h3F
`define MAX_N_WORD 8'h1F
`define ENH_WORDS 9'h100
`endif

// *** include/bypass_host_pkg.sv ***
// Purpose: Types for the unlock bypass host sequencer
// Assumes: Constants header supplies widths
// Notes: Structs carry commands, buffer words and bus cycles
`include "bypass_host_consts.svh"
package bypass_host_pkg;
  typedef enum logic [3:0] {
    OP_READ = 4'h0,
    OP_ENTER = 4'h1,
    OP_EXIT = 4'h2,
    OP_PROGRAM = 4'h3,
    OP_BLK_ERASE = 4'h4,
    OP_ADD_BLOCK = 4'h5,
    OP_CHIP_ERASE = 4'h6,
    OP_BUF_PROG = 4'h7,
    OP_ENH_PROG = 4'h8,
    OP_READ_RESET = 4'h9,
    OP_ABORT_RESET = 4'hA
  } op_t;
  typedef struct packed {
    op_t op;
    logic [`AW-1:0] addr;
    logic [`DW-1:0] data;
    logic [7:0] count;
  } cmd_t;
  typedef struct packed {
    logic [`AW-1:0] target_write_address;
    logic [`DW-1:0] target_write_value;
  } wdata_t;
  typedef enum logic [1:0] {
    CYC_FIX = 2'h0,
    CYC_USER = 2'h1,
    CYC_END = 2'h2
  } cyc_kind_t;
  typedef struct packed {
    cyc_kind_t kind;
    logic [`AW-1:0] addr;
    logic [`DW-1:0] data;
  } cyc_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_PICK = 3'h1,
    ST_WAIT_DATA = 3'h2,
    ST_SETUP = 3'h3,
    ST_WR_LOW = 3'h4,
    ST_WR_HIGH = 3'h5,
    ST_RD = 3'h6
  } state_t;
endpackage

// *** hdl/bypass_host.sv ***
// Purpose: Host sequencer driving a parallel flash in unlock bypass mode
// Assumes: Flash pins and i_dq synchronous to i_clk
// Notes: One command at a time; buffer words stream on the wdata port
`timescale 1ns/10ps
`default_nettype none
`include "bypass_host_consts.svh"
module bypass_host
  import bypass_host_pkg::*;
#(
  parameter bit BYTE_MODE = 1'b0
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire cmd_t i_cmd,
  output logic o_cmd_ready,
  output logic o_cmd_error,
  input wire logic i_wdata_valid,
  input wire wdata_t i_wdata,
  output logic o_wdata_ready,
  output logic o_rvalid,
  output logic [`DW-1:0] o_rdata,
  output logic o_in_bypass,
  input wire logic i_vpp_request,
  output logic o_high_program_voltage_level,
  input wire logic i_rb_n,
  input wire logic [`DW-1:0] i_dq,
  output logic [`DW-1:0] o_dq,
  output logic o_dq_oe,
  output logic [`AW-1:0] o_addr,
  output logic o_ce_n,
  output logic o_oe_n,
  output logic o_we_n,
  output logic o_rp_n
);
  localparam logic [7:0] WR_CYC = 8'(`WR_CYC);
  localparam logic [7:0] RD_CYC = 8'(`RD_CYC);
  function automatic logic [`AW-1:0] unl(input logic second);
    unl = BYTE_MODE ? (second ? `UNLOCK2_BYTE : `UNLOCK1_BYTE) :
      (second ? `UNLOCK2_WORD : `UNLOCK1_WORD);
  endfunction
  // Bus cycle for a given step of an operation
  function automatic cyc_t cycle_of(input cmd_t c, input logic [8:0] s);
    logic [8:0] last;
    logic [`AW-1:0] blk0;
    cycle_of = '{kind: CYC_END, addr: '0, data: '0};
    last = 9'({1'b0, c.count} + 9'h002);
    blk0 = {c.addr[`AW-1:8], 8'h00};
    unique case (c.op)
      OP_ENTER, OP_ABORT_RESET: begin
        if (s == 9'h000) begin
          cycle_of = '{CYC_FIX, unl(1'b0), `D_UNLOCK1};
        end else if (s == 9'h001) begin
          cycle_of = '{CYC_FIX, unl(1'b1), `D_UNLOCK2};
        end else if (s == 9'h002) begin
          cycle_of = '{CYC_FIX, unl(1'b0),
            (c.op == OP_ENTER) ? `D_ENTER : `D_RESET};
        end
      end
      OP_PROGRAM: begin
        if (s == 9'h000) begin
          cycle_of = '{CYC_FIX, '0, `D_PROGRAM};
        end else if (s == 9'h001) begin
          cycle_of = '{CYC_FIX, c.addr, c.data};
        end
      end
      OP_BLK_ERASE, OP_CHIP_ERASE: begin
        if (s == 9'h000) begin
          cycle_of = '{CYC_FIX, '0, `D_ERASE_SETUP};
        end else if (s == 9'h001) begin
          cycle_of = (c.op == OP_BLK_ERASE) ?
            '{CYC_FIX, c.addr, `D_BLOCK_ERASE} :
            '{CYC_FIX, '0, `D_CHIP_ERASE};
        end
      end
      OP_ADD_BLOCK: begin
        if (s == 9'h000) begin
          cycle_of = '{CYC_FIX, c.addr, `D_BLOCK_ERASE};
        end
      end
      OP_BUF_PROG: begin
        if (s == 9'h000) begin
          cycle_of = '{CYC_FIX, c.addr, `D_BUF_LOAD};
        end else if (s == 9'h001) begin
          cycle_of = '{CYC_FIX, c.addr, `DW'(c.count)};
        end else if (s <= last) begin
          cycle_of = '{CYC_USER, '0, '0};
        end else if (s == last + 9'h001) begin
          cycle_of = '{CYC_FIX, c.addr, `D_CONFIRM};
        end
      end
      OP_ENH_PROG: begin
        if (s == 9'h000) begin
          cycle_of = '{CYC_FIX, c.addr, `D_ENH_LOAD};
        end else if (s <= `ENH_WORDS) begin
          cycle_of = '{CYC_USER, '0, '0};
        end else if (s == `ENH_WORDS + 9'h001) begin
          cycle_of = '{CYC_FIX, blk0, `D_CONFIRM};
        end
      end
      OP_EXIT: begin
        if (s == 9'h000) begin
          cycle_of = '{CYC_FIX, '0, `D_EXIT1};
        end else if (s == 9'h001) begin
          cycle_of = '{CYC_FIX, '0, `D_EXIT2};
        end
      end
      OP_READ_RESET: begin
        if (s == 9'h000) begin
          cycle_of = '{CYC_FIX, '0, `D_RESET};
        end
      end
      default: cycle_of = '{CYC_END, '0, '0};
    endcase
  endfunction
  // Refusing here keeps invalid sequences off the flash bus entirely
  function automatic logic legal(input cmd_t c, input logic byp,
                                 input logic open_erase);
    unique case (c.op)
      OP_READ, OP_ABORT_RESET, OP_READ_RESET: legal = 1'b1;
      OP_ENTER: legal = !byp;
      OP_ADD_BLOCK: legal = byp && open_erase;
      OP_BUF_PROG: legal = byp && (c.count <= (BYTE_MODE ?
        `MAX_N_BYTE : `MAX_N_WORD));
      OP_ENH_PROG: legal = byp && !BYTE_MODE;
      OP_EXIT, OP_PROGRAM, OP_BLK_ERASE, OP_CHIP_ERASE:
        legal = byp;
      default: legal = 1'b0;
    endcase
  endfunction
  state_t state, next_state;
  cmd_t cmd, next_cmd;
  logic [8:0] step, next_step;
  logic [7:0] timer, next_timer;
  logic erase_open, next_erase_open;
  logic next_cmd_ready, next_cmd_error, next_wdata_ready, next_rvalid;
  logic [`DW-1:0] next_rdata, next_dq;
  logic next_in_bypass, next_vpp, next_dq_oe, next_ce_n, next_oe_n, next_we_n;
  logic [`AW-1:0] next_addr;
  cyc_t cyc;
  assign cyc = cycle_of(cmd, step);
  always_comb begin
    next_state = state;
    next_cmd = cmd;
    next_step = step;
    next_timer = timer;
    next_erase_open = erase_open;
    next_cmd_ready = 1'b0;
    next_cmd_error = 1'b0;
    next_wdata_ready = o_wdata_ready;
    next_rvalid = 1'b0;
    next_rdata = o_rdata;
    next_in_bypass = o_in_bypass;
    next_vpp = i_vpp_request;
    next_dq = o_dq;
    next_dq_oe = o_dq_oe;
    next_addr = o_addr;
    next_ce_n = o_ce_n;
    next_oe_n = o_oe_n;
    next_we_n = o_we_n;
    if (o_high_program_voltage_level) begin
      next_in_bypass = 1'b1;
    end
    unique case (state)
      ST_IDLE: begin
        next_cmd_ready = 1'b1;
        if (i_cmd_valid && o_cmd_ready) begin
          next_cmd_ready = 1'b0;
          next_cmd = i_cmd;
          next_step = '0;
          if (!legal(i_cmd, o_in_bypass, erase_open)) begin
            next_cmd_error = 1'b1;
          end else if (i_cmd.op == OP_READ) begin
            next_addr = i_cmd.addr;
            next_ce_n = 1'b0;
            next_oe_n = 1'b0;
            next_dq_oe = 1'b0;
            next_timer = RD_CYC;
            next_state = ST_RD;
          end else begin
            next_erase_open = (i_cmd.op == OP_BLK_ERASE) ||
              (i_cmd.op == OP_ADD_BLOCK);
            next_state = ST_PICK;
          end
        end
      end
      ST_PICK: begin
        if (cyc.kind == CYC_END) begin
          if (cmd.op == OP_ENTER) begin
            next_in_bypass = 1'b1;
          end else if (cmd.op == OP_EXIT) begin
            next_in_bypass = 1'b0;
          end
          next_dq_oe = 1'b0;
          next_cmd_ready = 1'b1;
          next_state = ST_IDLE;
        end else if (step == 9'h000 && !i_rb_n &&
                     cmd.op != OP_ADD_BLOCK) begin
          // Busy: a new command other than a read or an add block must wait for the running operation
          next_state = ST_PICK;
        end else if (cyc.kind == CYC_USER) begin
          next_wdata_ready = 1'b1;
          next_state = ST_WAIT_DATA;
        end else begin
          next_addr = cyc.addr;
          next_dq = cyc.data;
          next_state = ST_SETUP;
        end
      end
      ST_WAIT_DATA: begin
        if (i_wdata_valid && o_wdata_ready) begin
          next_wdata_ready = 1'b0;
          next_addr = (cmd.op == OP_ENH_PROG) ?
            {cmd.addr[`AW-1:8], 8'(step - 9'h001)} :
            i_wdata.target_write_address;
          next_dq = i_wdata.target_write_value;
          next_state = ST_SETUP;
        end
      end
      ST_SETUP: begin
        next_ce_n = 1'b0;
        next_dq_oe = 1'b1;
        next_we_n = 1'b0;
        next_timer = WR_CYC;
        next_state = ST_WR_LOW;
      end
      ST_WR_LOW: begin
        next_timer = timer - 8'h01;
        if (timer == 8'h01) begin
          next_we_n = 1'b1;
          next_ce_n = 1'b1;
          next_state = ST_WR_HIGH;
        end
      end
      ST_WR_HIGH: begin
        next_step = step + 9'h001;
        next_state = ST_PICK;
      end
      ST_RD: begin
        next_timer = timer - 8'h01;
        if (timer == 8'h01) begin
          next_rdata = i_dq;
          next_rvalid = 1'b1;
          next_ce_n = 1'b1;
          next_oe_n = 1'b1;
          next_cmd_ready = 1'b1;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state <= ST_IDLE;
      cmd <= '0;
      step <= '0;
      timer <= '0;
      erase_open <= 1'b0;
      o_cmd_ready <= 1'b0;
      o_cmd_error <= 1'b0;
      o_wdata_ready <= 1'b0;
      o_rvalid <= 1'b0;
      o_rdata <= '0;
      o_in_bypass <= 1'b0;
      o_high_program_voltage_level <= 1'b0;
      o_dq <= '0;
      o_dq_oe <= 1'b0;
      o_addr <= '0;
      o_ce_n <= 1'b1;
      o_oe_n <= 1'b1;
      o_we_n <= 1'b1;
      o_rp_n <= 1'b0;
    end else begin
      state <= next_state;
      cmd <= next_cmd;
      step <= next_step;
      timer <= next_timer;
      erase_open <= next_erase_open;
      o_cmd_ready <= next_cmd_ready;
      o_cmd_error <= next_cmd_error;
      o_wdata_ready <= next_wdata_ready;
      o_rvalid <= next_rvalid;
      o_rdata <= next_rdata;
      o_in_bypass <= next_in_bypass;
      o_high_program_voltage_level <= next_vpp;
      o_dq <= next_dq;
      o_dq_oe <= next_dq_oe;
      o_addr <= next_addr;
      o_ce_n <= next_ce_n;
      o_oe_n <= next_oe_n;
      o_we_n <= next_we_n;
      o_rp_n <= 1'b1;
    end
  end
endmodule
`default_nettype wire

// *** testbench/bypass_host_chk.sv ***
// Purpose: Port assertions for bypass_host
// Assumes: One clock, async active-low reset
// Notes: Read data is due two cycles after the take
`timescale 1ns/10ps
`default_nettype none
module bypass_host_chk
  import bypass_host_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_cmd_valid,
  input wire cmd_t i_cmd,
  input wire logic o_cmd_ready,
  input wire logic o_cmd_error,
  input wire logic o_rvalid,
  input wire logic o_in_bypass,
  input wire logic i_vpp_request,
  input wire logic o_high_program_voltage_level,
  input wire logic o_dq_oe,
  input wire logic o_ce_n,
  input wire logic o_oe_n,
  input wire logic o_we_n
);
  logic take;
  assign take = i_cmd_valid && o_cmd_ready;
  default clocking @(posedge i_clk);
  endclocking
  default disable iff (!i_rst_n);
  write_strobe_a: assert property (
    !o_we_n |-> !o_ce_n && o_oe_n && o_dq_oe) else $error("bad write");
  read_strobe_a: assert property (
    !o_oe_n |-> !o_ce_n && o_we_n && !o_dq_oe) else $error("bad read");
  read_latency_a: assert property (
    take && i_cmd.op == OP_READ |-> ##2 o_rvalid) else $error("no data");
  rvalid_pulse_a: assert property (
    o_rvalid |=> !o_rvalid) else $error("long rvalid");
  enter_refused_a: assert property (
    take && i_cmd.op == OP_ENTER && o_in_bypass |-> ##[1:2] o_cmd_error)
    else $error("enter kept");
  program_refused_a: assert property (
    take && i_cmd.op == OP_PROGRAM && !o_in_bypass |-> ##[1:2] o_cmd_error)
    else $error("program kept");
  error_pulse_a: assert property (
    o_cmd_error |=> !o_cmd_error) else $error("long error");
  vpp_follow_a: assert property (
    i_vpp_request |=> o_high_program_voltage_level) else $error("no vpp");
  vpp_bypass_a: assert property (
    o_high_program_voltage_level && !o_in_bypass |=> o_in_bypass)
    else $error("vpp no bypass");
endmodule
bind bypass_host bypass_host_chk chk (.i_clk, .i_rst_n, .i_cmd_valid,
  .i_cmd, .o_cmd_ready, .o_cmd_error, .o_rvalid, .o_in_bypass,
  .i_vpp_request, .o_high_program_voltage_level, .o_dq_oe, .o_ce_n,
  .o_oe_n, .o_we_n);
`default_nettype wire

// *** testbench/flash_model.sv ***
// Purpose: Flash device model for the bypass host bench
// Assumes: Word organization; writes taken on the write strobe
// Notes: Busy shortened to 20 clocks; status value is arbitrary
`timescale 1ns/10ps
`default_nettype none
`include "bypass_host_consts.svh"
module flash_model #(
  parameter logic [15:0] STATUS = 16'h0080
) (
  input wire logic i_clk,
  input wire logic [22:0] i_addr,
  input wire logic [15:0] i_dq,
  input wire logic i_ce_n,
  input wire logic i_oe_n,
  input wire logic i_we_n,
  input wire logic i_vpp,
  output logic [15:0] o_dq,
  output logic o_rb_n
);
  logic [22:0] la;
  // Known history, so the strobe edge at reset cannot poison the mode
  logic [15:0] ld = '0, p1 = '0, p2 = '0;
  logic bypass = 1'b0;
  int nwr, ops, nprog, lcnt, busy, ph;
  assign o_rb_n = busy == 0;
  // Released bus toggles so stale data never looks valid
  assign o_dq = (i_ce_n || i_oe_n) ? {8{i_clk, !i_clk}} :
    busy != 0 ? STATUS : i_addr[15:0] ^ 16'h5A5A;
  always @(posedge i_clk) begin
    if (busy > 0)
      busy--;
  end
  always @(negedge i_we_n) begin
    la = i_addr;
    ld = i_dq;
  end
  always @(posedge i_we_n) begin
    nwr++;
    if (lcnt != 0) begin
      lcnt--;
      ph = lcnt == 0 ? 5 : 0;
    end else if (ph == 4) begin
      lcnt = int'(ld[7:0]) + 1;
      nprog = lcnt;
      ph = 0;
    end else if (ph == 1 || ph == 2 && ld == `D_CHIP_ERASE ||
        ph == 5 && ld == `D_CONFIRM ||
        (ph == 2 || ph == 3) && ld == `D_BLOCK_ERASE) begin
      ops++;
      busy = 20;
      ph = ld == `D_BLOCK_ERASE && ph != 1 ? 3 : 0;
    end else if (ph == 6 && ld == `D_EXIT2) begin
      bypass = 1'b0;
      ph = 0;
    end else if (!bypass && !i_vpp) begin
      bypass = p2 == `D_UNLOCK1 && p1 == `D_UNLOCK2 && ld == `D_ENTER;
    end else begin
      // Unknown data and read/reset keep the mode
      ph = ld == `D_PROGRAM ? 1 : ld == `D_ERASE_SETUP ? 2 :
        ld == `D_BUF_LOAD ? 4 : ld == `D_EXIT1 ? 6 : 0;
      if (ld == `D_ENH_LOAD) begin
        lcnt = 256;
        nprog = 256;
      end
    end
    p2 = p1;
    p1 = ld;
  end
endmodule
`default_nettype wire

// *** testbench/tb_flash_unlock_bypass_cmd_decoder.sv ***
// Purpose: Self-checking bench for bypass_host
// Assumes: Word organization, 10 MHz clock
// Notes: Buffer words come with random stalls
`timescale 1ns/10ps
`default_nettype none
module tb_flash_unlock_bypass_cmd_decoder
  import bypass_host_pkg::*;
;
  localparam logic [15:0] ST = 16'h0080;
  logic i_clk, i_rst_n, i_cmd_valid, i_wdata_valid, i_vpp_request, i_rb_n;
  logic o_cmd_ready, o_cmd_error, o_wdata_ready, o_rvalid, o_in_bypass;
  logic o_high_program_voltage_level, o_dq_oe, o_ce_n, o_oe_n, o_we_n;
  logic o_rp_n;
  cmd_t i_cmd;
  wdata_t i_wdata;
  logic [15:0] o_rdata, i_dq, o_dq, d;
  logic [22:0] o_addr, a;
  logic [7:0] n;
  int errors, n_compared, cyc, n0;
  bypass_host uut (.i_clk, .i_rst_n, .i_cmd_valid, .i_cmd, .o_cmd_ready,
    .o_cmd_error, .i_wdata_valid, .i_wdata, .o_wdata_ready, .o_rvalid,
    .o_rdata, .o_in_bypass, .i_vpp_request, .o_high_program_voltage_level,
    .i_rb_n, .i_dq, .o_dq, .o_dq_oe, .o_addr, .o_ce_n, .o_oe_n, .o_we_n,
    .o_rp_n);
  flash_model #(.STATUS(ST)) fm (.i_clk, .i_addr(o_addr), .i_dq(o_dq),
    .i_ce_n(o_ce_n), .i_oe_n(o_oe_n), .i_we_n(o_we_n),
    .i_vpp(o_high_program_voltage_level), .o_dq(i_dq), .o_rb_n(i_rb_n));
  initial begin
    i_clk = 1'b0;
    forever #50 i_clk = ~i_clk;
  end
  task automatic complete_run;
    $display("Compared %0d, errors %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // Array content that the model shows for an idle read
  function automatic logic [15:0] array_word(input logic [22:0] ad);
    return ad[15:0] ^ 16'h5A5A;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", nm, e, g);
      errors++;
    end
  endtask
  task automatic idle;
    do @(negedge i_clk); while (o_cmd_ready !== 1'b1);
  endtask
  // Error pulse may land one or two cycles after the take
  task automatic cmd(input op_t op, input logic e);
    logic x;
    idle();
    @(posedge i_clk);
    i_cmd_valid <= 1'b1;
    i_cmd <= {op, a, d, n};
    @(posedge i_clk);
    i_cmd_valid <= 1'b0;
    @(negedge i_clk);
    x = o_cmd_error;
    @(negedge i_clk);
    chk("cmd_error", 32'(e), 32'(x | o_cmd_error));
    chk("rvalid", 32'(op == OP_READ), 32'(o_rvalid));
    idle();
  endtask
  task automatic rd(input logic [15:0] e);
    cmd(OP_READ, 1'b0);
    chk("rdata", 32'(e), 32'(o_rdata));
  endtask
  // Offer stays up until taken, then the next word is drawn
  always @(posedge i_clk) begin
    cyc++;
    if (!i_wdata_valid || o_wdata_ready) begin
      i_wdata_valid <= ($urandom % 4) != 0;
      i_wdata <= {a[22:5], 5'($urandom), 16'($urandom)};
    end
    if (cyc > 20000) begin
      errors++;
      complete_run();
    end
  end
  initial begin
    void'($urandom(32'hAE1D6009));
    i_rst_n = 1'b0;
    i_cmd_valid = 1'b0;
    i_wdata_valid = 1'b0;
    i_vpp_request = 1'b0;
    {i_cmd, i_wdata, a, d, n} = '0;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    a = 23'($urandom);
    rd(array_word(a));
    chk("rp_n", 1, 32'(o_rp_n));
    cmd(OP_PROGRAM, 1'b1);
    cmd(OP_ENTER, 1'b0);
    chk("bypass", 1, 32'(fm.bypass & o_in_bypass));
    cmd(OP_ENTER, 1'b1);
    for (int i = 0; i < 3; i++) begin
      a = 23'($urandom);
      d = 16'($urandom);
      cmd(OP_PROGRAM, 1'b0);
      chk("prog addr", 32'(a), 32'(fm.la));
      chk("prog data", 32'(d), 32'(fm.ld));
      rd(ST);
    end
    wait (i_rb_n === 1'b1);
    rd(array_word(a));
    cmd(OP_ADD_BLOCK, 1'b1);
    n0 = fm.ops;
    cmd(OP_BLK_ERASE, 1'b0);
    cmd(OP_ADD_BLOCK, 1'b0);
    cmd(OP_ADD_BLOCK, 1'b0);
    rd(ST);
    cmd(OP_CHIP_ERASE, 1'b0);
    chk("ops", 4, fm.ops - n0);
    for (int i = 0; i < 3; i++) begin
      n = i == 0 ? 8'h00 : i == 1 ? 8'h1F : 8'($urandom % 32);
      n0 = fm.nwr;
      cmd(OP_BUF_PROG, 1'b0);
      chk("buf", 32'(n) + 4, fm.nwr - n0);
      chk("words", 32'(n) + 1, fm.nprog);
    end
    n = 8'h20;
    cmd(OP_BUF_PROG, 1'b1);
    n0 = fm.nwr;
    cmd(OP_ENH_PROG, 1'b0);
    chk("enh", 258, fm.nwr - n0);
    chk("enh words", 256, fm.nprog);
    n0 = fm.nwr;
    cmd(OP_READ_RESET, 1'b0);
    cmd(OP_ABORT_RESET, 1'b0);
    chk("resets", 4, fm.nwr - n0);
    chk("kept", 1, 32'(fm.bypass & o_in_bypass));
    cmd(OP_EXIT, 1'b0);
    chk("left", 0, 32'(fm.bypass | o_in_bypass));
    @(posedge i_clk);
    i_vpp_request <= 1'b1;
    repeat (3) @(negedge i_clk);
    chk("vpp", 1, 32'(o_in_bypass));
    cmd(OP_PROGRAM, 1'b0);
    complete_run();
  end
endmodule
`default_nettype wire
